// ===== src/iso_rx_pkg.sv
// Constants and carriers for the isochronous receive start and filter block.
// Assumes a 16-bit Avalon-MM byte address and one 250 MHz clock.
package iso_rx_pkg;
	// ==========================================
	// Register map
	localparam int NUM_CTX = 8;
	localparam logic [15:0] CTX_STRIDE = 16'h0020;
	localparam logic [15:0] CTRL_BASE = 16'h0400;
	localparam logic [15:0] PTR_BASE = 16'h040C;
	localparam logic [15:0] MATCH_BASE = 16'h410C;
	localparam logic [15:0] MASK_LO_ADDR = 16'h0600;
	localparam logic [15:0] MASK_HI_ADDR = 16'h0604;
	localparam logic [15:0] LINK_CTRL_ADDR = 16'h0610;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// ==========================================
	// Field positions
	localparam int CTRL_RUN = 15;
	localparam int CTRL_ACTIVE = 10;
	localparam int CTRL_CYC_EN = 29;
	localparam int CTRL_MULTI = 28;
	localparam int MATCH_TAG_LO = 28;
	localparam int MATCH_RSVD_HI = 27;
	localparam int MATCH_CYC_HI = 26;
	localparam int MATCH_CYC_LO = 12;
	localparam int MATCH_SYNC_HI = 11;
	localparam int MATCH_SYNC_LO = 8;
	localparam int MATCH_RSVD_LO = 7;
	localparam int MATCH_FILTER = 6;
	localparam int PTR_ADDR_LO = 4;
	localparam int TMR_SEC_LO = 25;
	localparam int TMR_CYC_HI = 24;
	localparam int TMR_CYC_LO = 12;
	localparam int LINK_LOCK = 0;
	localparam logic [1:0] TAG_01 = 2'h1;
	localparam logic [31:0] MATCH_RSVD_MASK = 32'h0800_0080;
	localparam int BUF_DEPTH = 2;
	// ==========================================
	// Carriers
	typedef struct packed {
		logic [1:0] tag;
		logic [5:0] chan;
		logic [3:0] sync;
		logic [31:0] data;
	} pkt_t;
	typedef struct packed {
		logic [7:0] ctx_mask;
		logic [31:0] data;
	} out_t;
	typedef struct packed {
		logic [2:0] ctx;
		logic [27:0] first_block_address;
		logic [3:0] count;
	} fetch_t;
endpackage : iso_rx_pkg

// ===== src/iso_rx_start_filter.sv
// Start pointer, start-cycle and packet acceptance for eight iso receive contexts.
// Assumes a synchronous Avalon-MM master and a link layer that offers one packet
// word at a time with its tag, channel and sync fields.
// How it works
// - Run set fetches first block at pointer
// - Eight contexts, registers every 32 bytes
// - Pointer low nibble gives descriptor count
// - Tag enable bits gate accepted tags
// - Cycle-match start waits for timer equality
// - Wait-sync descriptors compare sync field
// - Tag-01 filter needs sync top bits zero
// - Filter lock forces filter bit, read-only
// - Accept only the selected channel
// - Match bits 27 and 7 read zero
// - Multi-channel mode uses channel masks
// - Hardware clears cycle-match enable on activity
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
module iso_rx_start_filter (
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic [15:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic [31:0] CYCLE_TIMER_I,
	input wire logic [7:0] WAIT_SYNC_I,
	input wire iso_rx_pkg::pkt_t PKT_I,
	input wire logic PKT_VALID_I,
	output logic PKT_READY_O,
	output iso_rx_pkg::out_t OUT_O,
	output logic OUT_VALID_O,
	input wire logic OUT_READY_I,
	output iso_rx_pkg::fetch_t FETCH_O,
	output logic FETCH_VALID_O,
	input wire logic FETCH_READY_I
);
	import iso_rx_pkg::*;

	// ==========================================
	// Decoding
	function automatic logic ctx_hit(input logic [15:0] a, input logic [15:0] base);
		logic [15:0] off;
		off = a - base;
		ctx_hit = (off[15:8] == 8'h00) && (off[4:0] == 5'h00);
	endfunction : ctx_hit

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		merge = r;
	endfunction : merge

	logic ack;
	logic [31:0] ctrl [NUM_CTX];
	logic [31:0] ptr [NUM_CTX];
	logic [31:0] match [NUM_CTX];
	logic [31:0] mask_lo;
	logic [31:0] mask_hi;
	logic [31:0] link_ctrl;
	logic [7:0] active;
	logic [7:0] pend;
	logic [7:0] run_q;
	logic [7:0] acc;
	logic [31:0] rd_mux;
	logic [2:0] fetch_ctx;
	logic [1:0] wr_ptr;
	logic [1:0] rd_ptr;
	logic [1:0] fill;
	out_t buf_mem [BUF_DEPTH];

	wire req = AVS_READ_I | AVS_WRITE_I;
	wire wr_go = AVS_WRITE_I & ack;
	wire lock = link_ctrl[LINK_LOCK];
	wire hit_ctrl = ctx_hit(AVS_ADDRESS_I, CTRL_BASE);
	wire hit_ptr = ctx_hit(AVS_ADDRESS_I, PTR_BASE);
	wire hit_match = ctx_hit(AVS_ADDRESS_I, MATCH_BASE);
	wire [2:0] idx_ctrl = 3'((AVS_ADDRESS_I - CTRL_BASE) >> 5);
	wire [2:0] idx_ptr = 3'((AVS_ADDRESS_I - PTR_BASE) >> 5);
	wire [2:0] idx_match = 3'((AVS_ADDRESS_I - MATCH_BASE) >> 5);
	wire [63:0] chan_mask = {mask_hi, mask_lo};
	wire [14:0] now_cycle = {CYCLE_TIMER_I[TMR_SEC_LO +: 2],
		CYCLE_TIMER_I[TMR_CYC_HI:TMR_CYC_LO]};
	wire buf_full = (fill == 2'(BUF_DEPTH));
	wire buf_empty = (fill == 2'h0);
	wire take = PKT_VALID_I & PKT_READY_O;
	wire push = take & (acc != 8'h00);
	wire pop = OUT_VALID_O & OUT_READY_I;

	// ==========================================
	// Bus slave: one wait cycle, then the access completes
	assign AVS_WAITREQUEST_O = req & ~ack;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux = ctrl[idx_ctrl];
			rd_mux[CTRL_ACTIVE] = active[idx_ctrl];
		end else if (hit_ptr) begin
			rd_mux = ptr[idx_ptr];
		end else if (hit_match) begin
			rd_mux = match[idx_match] & ~MATCH_RSVD_MASK;
			rd_mux[MATCH_FILTER] = match[idx_match][MATCH_FILTER] | lock;
		end else if (AVS_ADDRESS_I == MASK_LO_ADDR) begin
			rd_mux = mask_lo;
		end else if (AVS_ADDRESS_I == MASK_HI_ADDR) begin
			rd_mux = mask_hi;
		end else if (AVS_ADDRESS_I == LINK_CTRL_ADDR) begin
			rd_mux = link_ctrl;
		end
	end

	// Read data latched in the wait cycle so it is steady at completion
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			AVS_READDATA_O <= 32'h0000_0000;
		end else if (AVS_READ_I & ~ack) begin
			AVS_READDATA_O <= rd_mux;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			mask_lo <= REG_RESET;
			mask_hi <= REG_RESET;
			link_ctrl <= REG_RESET;
		end else if (wr_go) begin
			if (AVS_ADDRESS_I == MASK_LO_ADDR) begin
				mask_lo <= merge(mask_lo, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
			if (AVS_ADDRESS_I == MASK_HI_ADDR) begin
				mask_hi <= merge(mask_hi, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
			if (AVS_ADDRESS_I == LINK_CTRL_ADDR) begin
				link_ctrl <= merge(link_ctrl, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
		end
	end

	// ==========================================
	// Per-context registers, start and acceptance
	genvar n;
	generate
		for (n = 0; n < NUM_CTX; n++) begin : g_ctx
			wire wr_c = wr_go & hit_ctrl & (idx_ctrl == 3'(n));
			wire wr_p = wr_go & hit_ptr & (idx_ptr == 3'(n));
			wire wr_m = wr_go & hit_match & (idx_match == 3'(n));
			wire run = ctrl[n][CTRL_RUN];
			wire cyc_ok = now_cycle == match[n][MATCH_CYC_HI:MATCH_CYC_LO];
			wire go = run & ~active[n] & (~ctrl[n][CTRL_CYC_EN] | cyc_ok);
			wire tag_ok = match[n][MATCH_TAG_LO + 32'(PKT_I.tag)];
			wire filt = match[n][MATCH_FILTER] | lock;
			wire filt_ok = ~(filt & (PKT_I.tag == TAG_01) & (PKT_I.sync[3:2] != 2'h0));
			wire chan_ok = ctrl[n][CTRL_MULTI] ? chan_mask[PKT_I.chan]
				: (PKT_I.chan == match[n][5:0]);
			wire sync_ok = ~WAIT_SYNC_I[n]
				| (PKT_I.sync == match[n][MATCH_SYNC_HI:MATCH_SYNC_LO]);
			assign acc[n] = active[n] & tag_ok & filt_ok & chan_ok & sync_ok;

			always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					ctrl[n] <= REG_RESET;
				end else if (wr_c) begin
					ctrl[n] <= merge(ctrl[n], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				end else if (go) begin
					ctrl[n][CTRL_CYC_EN] <= 1'b0;
				end
			end

			// Stored count is kept as written; keeping it legal is software's job
			always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					ptr[n] <= REG_RESET;
					match[n] <= REG_RESET;
				end else begin
					if (wr_p) begin
						ptr[n] <= merge(ptr[n], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
					end
					if (wr_m) begin
						match[n] <= merge(match[n], AVS_WRITEDATA_I, AVS_BYTEENABLE_I)
							& ~MATCH_RSVD_MASK;
					end
				end
			end

			// Run rising queues a fetch; run falling drops activity
			always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
				if (!RST_N_I) begin
					run_q[n] <= 1'b0;
					pend[n] <= 1'b0;
					active[n] <= 1'b0;
				end else begin
					run_q[n] <= run;
					if (run & ~run_q[n]) begin
						pend[n] <= 1'b1;
					end else if (~run | (FETCH_VALID_O & FETCH_READY_I
						& (fetch_ctx == 3'(n)))) begin
						pend[n] <= 1'b0;
					end
					if (~run) begin
						active[n] <= 1'b0;
					end else if (go) begin
						active[n] <= 1'b1;
					end
				end
			end

			AST_CYC_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
				$rose(active[n]) |-> ~ctrl[n][CTRL_CYC_EN])
				else $error("cycle enable not cleared on start");
			AST_CYC_START: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
				$rose(active[n]) & $past(ctrl[n][CTRL_CYC_EN])
				|-> $past(now_cycle) == match[n][MATCH_CYC_HI:MATCH_CYC_LO])
				else $error("context started on wrong cycle");
		end
	endgenerate

	// ==========================================
	// Fetch request: lowest pending context first
	always_comb begin
		fetch_ctx = 3'h0;
		for (int i = NUM_CTX - 1; i >= 0; i--) begin
			if (pend[i]) begin
				fetch_ctx = 3'(i);
			end
		end
	end

	assign FETCH_VALID_O = pend != 8'h00;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			FETCH_O <= '0;
		end else begin
			FETCH_O.ctx <= fetch_ctx;
			FETCH_O.first_block_address <= ptr[fetch_ctx][31:PTR_ADDR_LO];
			FETCH_O.count <= ptr[fetch_ctx][3:0];
		end
	end

	// ==========================================
	// Two-entry buffer; a stalled receiver stalls the link
	assign PKT_READY_O = ~buf_full;
	assign OUT_VALID_O = ~buf_empty;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_ptr <= 2'h0;
			rd_ptr <= 2'h0;
			fill <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr <= 2'(wr_ptr[0] + 1'b1);
			end
			if (pop) begin
				rd_ptr <= 2'(rd_ptr[0] + 1'b1);
			end
			fill <= 2'(fill + 2'(push) - 2'(pop));
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (push) begin
			buf_mem[wr_ptr[0]] <= '{ctx_mask: acc, data: PKT_I.data};
		end
	end

	assign OUT_O = buf_mem[rd_ptr[0]];

	// ==========================================
	// Checks
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	AST_RSVD_ZERO: assert property (AVS_READ_I & ~ack & hit_match ##1 1'b1 |->
		(AVS_READDATA_O & MATCH_RSVD_MASK) == 32'h0)
		else $error("match reserved bits read nonzero");
	AST_LOCK_FORCE: assert property (AVS_READ_I & ~ack & hit_match & lock |=>
		AVS_READDATA_O[MATCH_FILTER])
		else $error("locked filter bit reads zero");
	AST_WAIT_ONE: assert property ($rose(req) |-> AVS_WAITREQUEST_O ##1 ~AVS_WAITREQUEST_O)
		else $error("access not completed in two cycles");
	AST_FETCH_RUN: assert property ($rose(ctrl[0][CTRL_RUN]) |=> pend[0])
		else $error("run did not queue a fetch");
	AST_FETCH_ADDR: assert property (FETCH_VALID_O & $stable(pend) & $stable(fetch_ctx)
		& $stable(ptr[fetch_ctx]) |-> FETCH_O.first_block_address == ptr[fetch_ctx][31:4])
		else $error("fetch address differs from pointer");
	AST_TAG_GATE: assert property (acc[0] |-> match[0][MATCH_TAG_LO + 32'(PKT_I.tag)])
		else $error("disabled tag accepted");
	AST_FILTER: assert property (acc[0] & (PKT_I.tag == TAG_01) & (match[0][6] | lock)
		|-> PKT_I.sync[3:2] == 2'h0)
		else $error("tag-01 packet passed sync filter");
	AST_CHAN: assert property (acc[0] & ~ctrl[0][CTRL_MULTI] |-> PKT_I.chan == match[0][5:0])
		else $error("wrong channel accepted");
	AST_MULTI: assert property (acc[0] & ctrl[0][CTRL_MULTI] |-> chan_mask[PKT_I.chan])
		else $error("masked channel accepted");
	AST_SYNC: assert property (acc[0] & WAIT_SYNC_I[0] |-> PKT_I.sync == match[0][11:8])
		else $error("sync mismatch accepted");
	AST_DROP: assert property (take & (acc == 8'h00) |=>
		fill == 2'($past(fill) - 2'($past(pop))))
		else $error("rejected packet buffered");
	AST_PTR_KEEP: assert property (~(wr_go & hit_ptr) |=> $stable(ptr[0]))
		else $error("pointer changed without write");

	COV_START: cover property ($rose(active[0]));
	COV_FULL: cover property (buf_full & ~OUT_READY_I);
	COV_ACCEPT: cover property (push & acc[1]);
	COV_FETCH: cover property (FETCH_VALID_O & FETCH_READY_I);
endmodule : iso_rx_start_filter

// ===== testbench/iso_rx_link_model.sv
// Link layer model: offers queued iso packet beats one per cycle.
// Assumes a ready/valid sink that samples on the rising edge.
`timescale 1ns/10ps
module iso_rx_link_model (
	input wire logic clk,
	input wire logic ready_i,
	output iso_rx_pkg::pkt_t pkt_o,
	output logic valid_o
);
	import iso_rx_pkg::*;
	pkt_t q[$];
	initial begin
		valid_o = 1'b0;
		pkt_o = '0;
	end
	// ==========================================
	// Beat is held until taken; idle lines toggle so stale data never looks valid
	always @(posedge clk) begin
		if (!valid_o || ready_i) begin
			if (q.size() > 0) begin
				pkt_o <= q.pop_front();
				valid_o <= 1'b1;
			end else begin
				valid_o <= 1'b0;
				pkt_o <= ~pkt_o;
			end
		end
	end
endmodule : iso_rx_link_model

// ===== testbench/iso_rx_start_filter_tb.sv
// Self-checking bench for the iso receive start and filter block.
// Assumes the link model above and a one-wait-cycle register bus.
`timescale 1ns/10ps
module iso_rx_start_filter_tb;
	import iso_rx_pkg::*;
	logic clk, rst_n, rd, wr, wreq, frd, fvld, prdy, pvld, ordy, ovld;
	logic [15:0] adr;
	logic [31:0] wd, rdat, tmr, q;
	logic [7:0] wsync;
	pkt_t pkt;
	out_t out;
	fetch_t fet;
	logic [39:0] outq[$];
	int failures, checked;
	iso_rx_start_filter dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
		.AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
		.CYCLE_TIMER_I(tmr), .WAIT_SYNC_I(wsync), .PKT_I(pkt), .PKT_VALID_I(pvld),
		.PKT_READY_O(prdy), .OUT_O(out), .OUT_VALID_O(ovld), .OUT_READY_I(ordy),
		.FETCH_O(fet), .FETCH_VALID_O(fvld), .FETCH_READY_I(frd));
	iso_rx_link_model lnk (.clk(clk), .ready_i(prdy), .pkt_o(pkt), .valid_o(pvld));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ovld && ordy) outq.push_back(out);
	end
	// ==========================================
	// Shared tasks
	task end_of_test;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [39:0] s, input logic [39:0] e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task tmo(input int n);
		if (n >= 100) begin
			failures++;
			end_of_test;
		end
	endtask : tmo
	task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		n = 0;
		@(posedge clk);
		while (wreq !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		tmo(n);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task idle;
		int n;
		n = 0;
		while ((lnk.q.size() != 0 || pvld) && n < 100) begin
			@(posedge clk);
			n++;
		end
		tmo(n);
		repeat (3) @(posedge clk);
	endtask : idle
	// ==========================================
	// Scenarios
	task regs;
		bus(1'b1, MATCH_BASE + CTX_STRIDE, 32'hFFFF_FFFF);
		bus(1'b0, MATCH_BASE + CTX_STRIDE, 32'h0);
		chk("match1", q, 32'hF7FF_FF7F);
		bus(1'b1, PTR_BASE + CTX_STRIDE * 16'h7, 32'hDEAD_BEEF);
		bus(1'b0, PTR_BASE + CTX_STRIDE * 16'h7, 32'h0);
		chk("ptr7", q, 32'hDEAD_BEEF);
		bus(1'b0, 16'h0800, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(1'b1, MATCH_BASE + CTX_STRIDE, 32'h0);
		bus(1'b1, LINK_CTRL_ADDR, 32'h1);
		bus(1'b0, MATCH_BASE + CTX_STRIDE, 32'h0);
		chk("locked", q, 32'h0000_0040);
		bus(1'b1, LINK_CTRL_ADDR, 32'h0);
	endtask : regs
	task fetch;
		int n;
		// Count of eight is legal only in packet-per-buffer mode
		bus(1'b1, PTR_BASE + CTX_STRIDE * 16'h2, 32'h1234_5678);
		bus(1'b1, CTRL_BASE + CTX_STRIDE * 16'h2, 32'h0000_8000);
		n = 0;
		while (fvld !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		tmo(n);
		repeat (2) @(posedge clk);
		chk("fetch", 40'(fet), {5'h00, 3'h2, 28'h123_4567, 4'h8});
		frd <= 1'b1;
		repeat (2) @(posedge clk);
		chk("fetch done", 40'(fvld), 40'h0);
	endtask : fetch
	task filt;
		logic [39:0] ex[3];
		ex = '{{8'h01, 32'hA1}, {8'h01, 32'hC3}, {8'h01, 32'hF6}};
		ordy <= 1'b0;
		bus(1'b1, MATCH_BASE, 32'h3000_0345);
		bus(1'b1, CTRL_BASE, 32'h0000_8000);
		repeat (4) @(posedge clk);
		bus(1'b0, CTRL_BASE, 32'h0);
		chk("active0", q & 32'h0000_0400, 40'h400);
		lnk.q.push_back({2'h0, 6'h05, 4'h0, 32'hA1});
		lnk.q.push_back({2'h2, 6'h05, 4'h0, 32'hB2});
		lnk.q.push_back({2'h1, 6'h05, 4'h3, 32'hC3});
		lnk.q.push_back({2'h1, 6'h05, 4'h8, 32'hD4});
		lnk.q.push_back({2'h0, 6'h06, 4'h0, 32'hE5});
		repeat (20) @(posedge clk);
		chk("stall", 40'(prdy), 40'h0);
		ordy <= 1'b1;
		idle;
		wsync <= 8'h01;
		lnk.q.push_back({2'h0, 6'h05, 4'h3, 32'hF6});
		lnk.q.push_back({2'h0, 6'h05, 4'h4, 32'h17});
		idle;
		wsync <= 8'h00;
		chk("kept", 40'(outq.size()), 40'h3);
		foreach (ex[i]) chk("out", outq[i], ex[i]);
		outq.delete();
	endtask : filt
	task cyc;
		bus(1'b1, MATCH_BASE + CTX_STRIDE * 16'h3, 32'h1123_4007);
		bus(1'b1, CTRL_BASE + CTX_STRIDE * 16'h3, 32'h2000_8000);
		lnk.q.push_back({2'h0, 6'h07, 4'h0, 32'h44});
		idle;
		bus(1'b0, CTRL_BASE + CTX_STRIDE * 16'h3, 32'h0);
		chk("waiting", q & 32'h2000_0400, 40'h2000_0000);
		tmr <= 32'h0123_4000;
		repeat (4) @(posedge clk);
		bus(1'b0, CTRL_BASE + CTX_STRIDE * 16'h3, 32'h0);
		chk("started", q & 32'h2000_0400, 40'h400);
		lnk.q.push_back({2'h0, 6'h07, 4'h0, 32'h55});
		idle;
		chk("late out", 40'(outq.size()), 40'h1);
		chk("late data", outq[0], {8'h08, 32'h55});
	endtask : cyc
	task multi;
		outq.delete();
		// Context 0 is stopped first: its mode may not change while it runs
		bus(1'b1, CTRL_BASE, 32'h0);
		bus(1'b1, MASK_HI_ADDR, 32'h0000_0100);
		bus(1'b1, LINK_CTRL_ADDR, 32'h1);
		bus(1'b1, MATCH_BASE, 32'h3000_0000);
		bus(1'b1, CTRL_BASE, 32'h1000_8000);
		repeat (2) @(posedge clk);
		lnk.q.push_back({2'h0, 6'h28, 4'h0, 32'h66});
		lnk.q.push_back({2'h0, 6'h00, 4'h0, 32'h77});
		lnk.q.push_back({2'h1, 6'h28, 4'h8, 32'h99});
		lnk.q.push_back({2'h1, 6'h28, 4'h2, 32'hAA});
		idle;
		bus(1'b1, LINK_CTRL_ADDR, 32'h0);
		chk("multi out", 40'(outq.size()), 40'h2);
		chk("multi chan", outq[0], {8'h01, 32'h66});
		chk("lock filter", outq[1], {8'h01, 32'hAA});
		outq.delete();
	endtask : multi
	// ==========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		adr = 16'h0;
		wd = 32'h0;
		tmr = 32'h0;
		wsync = 8'h00;
		ordy = 1'b1;
		frd = 1'b0;
		failures = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		regs;
		fetch;
		filt;
		cyc;
		multi;
		end_of_test;
	end
endmodule : iso_rx_start_filter_tb
